// >>> logic/ealu_top.sv
`timescale 1ns/1ns
`include "ealu_consts.svh"

module ealu_top #(
   parameter logic [5:0] IO_REG_ADDR = `EALU_IO_ADDR_DEF,
   parameter logic [7:0] W1C_MASK = `EALU_W1C_DEF
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [7:0] io_event,
   output logic [15:0] result,
   output logic result_wide,
   output logic op_done,
   output logic busy,
   output logic [7:0] flags,
   output logic [7:0] io_status
);

   // ****************************************************************
   // elaboration checks
   // ****************************************************************
   if (IO_REG_ADDR > `EALU_IO_TOP) begin : g_bad_io_addr
      $error("io register address outside the bit-instruction range");
   end

   // ****************************************************************
   // arithmetic helpers
   // ****************************************************************
   // returns {h, v, c, r}
   function automatic logic [10:0] ealu_add8(input logic [7:0] a, input logic [7:0] b,
                                             input logic cin);
      logic [8:0] s;
      logic h;
      logic v;
      s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      h = (a[3] & b[3]) | (b[3] & ~s[3]) | (~s[3] & a[3]);
      v = (a[7] & b[7] & ~s[7]) | (~a[7] & ~b[7] & s[7]);
      return {h, v, s[8], s[7:0]};
   endfunction : ealu_add8

   // returns {h, v, c, r}; c is the borrow out
   function automatic logic [10:0] ealu_sub8(input logic [7:0] a, input logic [7:0] b,
                                             input logic bin);
      logic [8:0] d;
      logic h;
      logic v;
      d = {1'b0, a} - {1'b0, b} - {8'h00, bin};
      h = (~a[3] & b[3]) | (b[3] & d[3]) | (d[3] & ~a[3]);
      v = (a[7] & ~b[7] & ~d[7]) | (~a[7] & b[7] & d[7]);
      return {h, v, d[8], d[7:0]};
   endfunction : ealu_sub8

   // sign extension chosen per operand, low 16 bits of the product kept
   function automatic logic [15:0] ealu_prod8(input logic [7:0] a, input logic [7:0] b,
                                             input logic sa, input logic sb);
      logic [15:0] ea;
      logic [15:0] eb;
      logic [31:0] p;
      ea = {{8{sa & a[7]}}, a};
      eb = {{8{sb & b[7]}}, b};
      p = {16'h0000, ea} * {16'h0000, eb};
      return p[15:0];
   endfunction : ealu_prod8

   // ****************************************************************
   // state
   // ****************************************************************
   ealu_pkg::ealu_state_t st_r;
   ealu_pkg::ealu_state_t st_nxt;

   // ****************************************************************
   // datapath
   // ****************************************************************
   logic [15:0] ex_res;
   logic [7:0] ex_upd;
   logic [7:0] ex_flags;
   logic ex_wide;

   always_comb begin
      logic [10:0] s8;
      logic [15:0] pair;
      logic [15:0] w;
      logic [15:0] p;
      logic c;
      logic v;
      logic h;
      logic n;
      logic z;
      logic wz;
      s8 = 11'h000;
      pair = {st_r.oph, st_r.opa};
      w = 16'h0000;
      p = 16'h0000;
      c = st_r.flags[`EALU_F_C];
      v = 1'b0;
      h = st_r.flags[`EALU_F_H];
      wz = 1'b0;
      n = 1'b0;
      z = 1'b0;
      ex_res = {8'h00, st_r.opa};
      ex_upd = `EALU_UPD_NONE;
      ex_wide = 1'b0;
      case (st_r.op)
         ealu_pkg::op_add, ealu_pkg::op_add_carry: begin
            s8 = ealu_add8(st_r.opa, st_r.opb,
                           (st_r.op == ealu_pkg::op_add_carry) & st_r.flags[`EALU_F_C]);
            ex_upd = `EALU_UPD_ARITH;
         end
         ealu_pkg::op_sub, ealu_pkg::op_minus_immediate: begin
            s8 = ealu_sub8(st_r.opa, st_r.opb, 1'b0);
            ex_upd = `EALU_UPD_ARITH;
         end
         ealu_pkg::op_minus_with_borrow, ealu_pkg::op_minus_imm_borrow: begin
            s8 = ealu_sub8(st_r.opa, st_r.opb, st_r.flags[`EALU_F_C]);
            ex_upd = `EALU_UPD_ARITH;
         end
         ealu_pkg::op_twos_invert: begin
            s8 = ealu_sub8(8'h00, st_r.opa, 1'b0);
            ex_upd = `EALU_UPD_ARITH;
         end
         ealu_pkg::op_ones_invert: begin
            s8 = {1'b0, 1'b0, 1'b1, ~st_r.opa};
            ex_upd = `EALU_UPD_INV;
         end
         ealu_pkg::op_plus_one: begin
            s8 = ealu_add8(st_r.opa, 8'h01, 1'b0);
            ex_upd = `EALU_UPD_LOGIC;
         end
         ealu_pkg::op_minus_one: begin
            s8 = ealu_sub8(st_r.opa, 8'h01, 1'b0);
            ex_upd = `EALU_UPD_LOGIC;
         end
         ealu_pkg::op_and, ealu_pkg::op_mask_immediate: begin
            s8 = {3'h0, st_r.opa & st_r.opb};
            ex_upd = `EALU_UPD_LOGIC;
         end
         ealu_pkg::op_or, ealu_pkg::op_merge_immediate: begin
            s8 = {3'h0, st_r.opa | st_r.opb};
            ex_upd = `EALU_UPD_LOGIC;
         end
         ealu_pkg::op_set_bits_reg: begin
            s8 = {3'h0, st_r.opa | st_r.opb};
            ex_upd = `EALU_UPD_LOGIC;
         end
         ealu_pkg::op_clear_bits_reg: begin
            s8 = {3'h0, st_r.opa & (8'hFF - st_r.opb)};
            ex_upd = `EALU_UPD_LOGIC;
         end
         ealu_pkg::op_zero_sign_test: begin
            s8 = {3'h0, st_r.opa & st_r.opa};
            ex_upd = `EALU_UPD_LOGIC;
         end
         ealu_pkg::op_xor_regs: begin
            s8 = {3'h0, st_r.opa ^ st_r.opb};
            ex_upd = `EALU_UPD_LOGIC;
         end
         ealu_pkg::op_zero_reg: begin
            s8 = {3'h0, st_r.opa ^ st_r.opa};
            ex_upd = `EALU_UPD_LOGIC;
         end
         ealu_pkg::op_all_ones_reg: begin
            s8 = {3'h0, 8'hFF};
         end
         ealu_pkg::op_word_plus_immediate: begin
            w = pair + {10'h000, st_r.opb[5:0]};
            v = ~st_r.oph[7] & w[15];
            c = ~w[15] & st_r.oph[7];
            ex_upd = `EALU_UPD_WORD;
         end
         ealu_pkg::op_word_minus_immediate: begin
            w = pair - {10'h000, st_r.opb[5:0]};
            v = st_r.oph[7] & ~w[15];
            c = w[15] & ~st_r.oph[7];
            ex_upd = `EALU_UPD_WORD;
         end
         ealu_pkg::op_unsigned_product, ealu_pkg::op_signed_product,
         ealu_pkg::op_mixed_product: begin
            p = ealu_prod8(st_r.opa, st_r.opb, st_r.op != ealu_pkg::op_unsigned_product,
                          st_r.op == ealu_pkg::op_signed_product);
            w = p;
            c = p[15];
            ex_upd = `EALU_UPD_PROD;
         end
         ealu_pkg::op_frac_unsigned_product, ealu_pkg::op_frac_signed_product,
         ealu_pkg::op_frac_mixed_product: begin
            p = ealu_prod8(st_r.opa, st_r.opb,
                          st_r.op != ealu_pkg::op_frac_unsigned_product,
                          st_r.op == ealu_pkg::op_frac_signed_product);
            w = {p[14:0], 1'b0};
            c = p[15];
            ex_upd = `EALU_UPD_PROD;
         end
         default: begin
            ex_upd = `EALU_UPD_NONE;
         end
      endcase
      // byte ops come back through s8, word and product ops through w
      if (ex_upd == `EALU_UPD_WORD || ex_upd == `EALU_UPD_PROD) begin
         ex_wide = 1'b1;
         ex_res = w;
         n = w[15];
         wz = (w == 16'h0000);
      end else begin
         ex_res = {8'h00, s8[7:0]};
         c = s8[8];
         v = s8[9];
         h = s8[10];
         n = s8[7];
         wz = (s8[7:0] == 8'h00);
      end
      z = wz;
      ex_flags = st_r.flags;
      ex_flags[`EALU_F_C] = c;
      ex_flags[`EALU_F_Z] = z;
      ex_flags[`EALU_F_N] = n;
      ex_flags[`EALU_F_V] = v;
      ex_flags[`EALU_F_S] = n ^ v;
      ex_flags[`EALU_F_H] = h;
      ex_flags = (st_r.flags & ~ex_upd) | (ex_flags & ex_upd);
   end

   // ****************************************************************
   // bus, sequencing and io status
   // ****************************************************************
   always_comb begin
      logic acc;
      logic wr;
      logic [7:0] iov;
      logic [5:0] ioa;
      acc = psel & penable & st_r.pready;
      wr = acc & pwrite;
      iov = st_r.io_status;
      ioa = pwdata[5:0];
      st_nxt = st_r;
      st_nxt.done = 1'b0;
      st_nxt.pready = psel & penable & ~st_r.pready;
      // read data and error are loaded one cycle ahead of the completing edge
      if (psel & penable & ~st_r.pready) begin
         st_nxt.prdata = 32'h0000_0000;
         st_nxt.pslverr = 1'b0;
         case (paddr)
            `EALU_OFS_CTRL: begin
               st_nxt.prdata[4:0] = st_r.op;
               st_nxt.prdata[`EALU_CTRL_BUSY] = st_r.busy;
               st_nxt.prdata[`EALU_CTRL_CYC_LO +: 2] = st_r.cycles;
            end
            `EALU_OFS_OPA: st_nxt.prdata[7:0] = st_r.opa;
            `EALU_OFS_OPB: st_nxt.prdata[7:0] = st_r.opb;
            `EALU_OFS_OPH: st_nxt.prdata[7:0] = st_r.oph;
            `EALU_OFS_FLAGS: st_nxt.prdata[7:0] = st_r.flags;
            `EALU_OFS_RESULT: st_nxt.prdata[15:0] = st_r.result;
            `EALU_OFS_IO_CMD: st_nxt.prdata = 32'h0000_0000;
            `EALU_OFS_IO_STAT: st_nxt.prdata[7:0] = st_r.io_status;
            `EALU_OFS_ERR: st_nxt.prdata[1:0] = st_r.err;
            default: st_nxt.pslverr = 1'b1;
         endcase
      end
      // sequencer: count down the clocks of the latched operation
      if (st_r.busy) begin
         if (st_r.cnt == 2'h1) begin
            st_nxt.busy = 1'b0;
            st_nxt.done = 1'b1;
            st_nxt.result = ex_res;
            st_nxt.wide = ex_wide;
            st_nxt.flags = ex_flags;
         end else begin
            st_nxt.cnt = st_r.cnt - 2'h1;
         end
      end
      if (wr) begin
         case (paddr)
            `EALU_OFS_CTRL: begin
               // a start while busy or with an unknown code is dropped and flagged
               if (pwdata[`EALU_CTRL_START]) begin
                  if (st_r.busy || pwdata[4:0] >= `EALU_OP_COUNT) begin
                     st_nxt.err[1] = 1'b1;
                  end else begin
                     st_nxt.op = ealu_pkg::ealu_op_t'(pwdata[4:0]);
                     st_nxt.busy = 1'b1;
                     case (ealu_pkg::ealu_op_t'(pwdata[4:0]))
                        ealu_pkg::op_word_plus_immediate, ealu_pkg::op_word_minus_immediate,
                        ealu_pkg::op_unsigned_product, ealu_pkg::op_signed_product,
                        ealu_pkg::op_mixed_product, ealu_pkg::op_frac_unsigned_product,
                        ealu_pkg::op_frac_signed_product, ealu_pkg::op_frac_mixed_product: begin
                           st_nxt.cnt = `EALU_CLK_TWO;
                        end
                        default: st_nxt.cnt = `EALU_CLK_ONE;
                     endcase
                     st_nxt.cycles = st_nxt.cnt;
                  end
               end
            end
            `EALU_OFS_OPA: if (!st_r.busy) st_nxt.opa = pwdata[7:0];
            `EALU_OFS_OPB: if (!st_r.busy) st_nxt.opb = pwdata[7:0];
            `EALU_OFS_OPH: if (!st_r.busy) st_nxt.oph = pwdata[7:0];
            `EALU_OFS_FLAGS: if (!st_r.busy) st_nxt.flags = pwdata[7:0];
            `EALU_OFS_IO_CMD: begin
               if (ioa > `EALU_IO_TOP) begin
                  st_nxt.err[0] = 1'b1;
               end else if (ioa == IO_REG_ADDR) begin
                  // whole register is read, one bit changed, and written back
                  iov[pwdata[`EALU_IO_BIT_LO +: 3]] = pwdata[`EALU_IO_SET];
                  st_nxt.io_status = (iov & ~W1C_MASK)
                                   | (st_r.io_status & W1C_MASK & ~iov);
               end
            end
            `EALU_OFS_IO_STAT: begin
               st_nxt.io_status = (pwdata[7:0] & ~W1C_MASK)
                                | (st_r.io_status & W1C_MASK & ~pwdata[7:0]);
            end
            `EALU_OFS_ERR: st_nxt.err = st_r.err & ~pwdata[1:0];
            default: st_nxt.err = st_r.err;
         endcase
      end
      // hardware events win over a clear in the same cycle
      st_nxt.io_status = st_nxt.io_status | (io_event & W1C_MASK);
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         st_r <= '{prdata: 32'h0000_0000, pready: 1'b0, pslverr: 1'b0,
                   op: ealu_pkg::op_add, opa: 8'h00, opb: 8'h00, oph: 8'h00,
                   flags: `EALU_RST_FLAGS, result: 16'h0000, cycles: 2'h0, busy: 1'b0,
                   cnt: 2'h0, done: 1'b0, wide: 1'b0, io_status: `EALU_RST_IO,
                   err: 2'h0};
      end else begin
         st_r <= st_nxt;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign prdata = st_r.prdata;
   assign pready = st_r.pready;
   assign pslverr = st_r.pslverr;
   assign result = st_r.result;
   assign result_wide = st_r.wide;
   assign op_done = st_r.done;
   assign busy = st_r.busy;
   assign flags = st_r.flags;
   assign io_status = st_r.io_status;

endmodule : ealu_top

// >>> shared/ealu_consts.svh
`ifndef EALU_CONSTS_SVH
`define EALU_CONSTS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define EALU_OFS_CTRL 12'h000
`define EALU_OFS_OPA 12'h004
`define EALU_OFS_OPB 12'h008
`define EALU_OFS_OPH 12'h00C
`define EALU_OFS_FLAGS 12'h010
`define EALU_OFS_RESULT 12'h014
`define EALU_OFS_IO_CMD 12'h018
`define EALU_OFS_IO_STAT 12'h01C
`define EALU_OFS_ERR 12'h020

// ****************************************************************
// field positions and values
// ****************************************************************
`define EALU_CTRL_START 8
`define EALU_CTRL_BUSY 9
`define EALU_CTRL_CYC_LO 12
`define EALU_IO_BIT_LO 8
`define EALU_IO_SET 12
`define EALU_F_C 0
`define EALU_F_Z 1
`define EALU_F_N 2
`define EALU_F_V 3
`define EALU_F_S 4
`define EALU_F_H 5
`define EALU_UPD_ARITH 8'h2F
`define EALU_UPD_WORD 8'h1F
`define EALU_UPD_LOGIC 8'h0E
`define EALU_UPD_INV 8'h0F
`define EALU_UPD_PROD 8'h03
`define EALU_UPD_NONE 8'h00
`define EALU_OP_COUNT 5'h1C
`define EALU_IO_TOP 6'h1F
`define EALU_IO_ADDR_DEF 6'h0B
`define EALU_W1C_DEF 8'hF0
`define EALU_RST_FLAGS 8'h00
`define EALU_RST_IO 8'h00

// ****************************************************************
// timing
// ****************************************************************
`define EALU_CLK_ONE 2'h1
`define EALU_CLK_TWO 2'h2

`endif

// >>> shared/ealu_pkg.sv
package ealu_pkg;

   typedef enum logic [4:0] {
      op_add, op_add_carry, op_word_plus_immediate, op_sub, op_minus_immediate,
      op_minus_with_borrow, op_minus_imm_borrow, op_word_minus_immediate,
      op_and, op_mask_immediate, op_or, op_merge_immediate, op_xor_regs,
      op_ones_invert, op_twos_invert, op_set_bits_reg, op_clear_bits_reg,
      op_plus_one, op_minus_one, op_zero_sign_test, op_zero_reg, op_all_ones_reg,
      op_unsigned_product, op_signed_product, op_mixed_product,
      op_frac_unsigned_product, op_frac_signed_product, op_frac_mixed_product
   } ealu_op_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      ealu_op_t op;
      logic [7:0] opa;
      logic [7:0] opb;
      logic [7:0] oph;
      logic [7:0] flags;
      logic [15:0] result;
      logic [1:0] cycles;
      logic busy;
      logic [1:0] cnt;
      logic done;
      logic wide;
      logic [7:0] io_status;
      logic [1:0] err;
   } ealu_state_t;

endpackage : ealu_pkg

// >>> verification/ealu_host.sv
`timescale 1ns/1ns
// ****************************************************************
// register bus master standing in for the core decoder
// ****************************************************************
module ealu_host (
   input wire logic ref_clk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
   end

   // request held until pready is seen high; a bounded wait flags a hang
   task xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
         output logic [31:0] q, output logic err, output logic to);
      to = 1'b1;
      q = 32'h00000000;
      err = 1'b0;
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wr ? d : 32'h00000000;
      @(posedge ref_clk);
      penable <= 1'b1;
      for (int n = 0; n < 16 && to; n++) begin
         @(posedge ref_clk);
         if (pready === 1'b1) begin
            q = prdata;
            err = pslverr;
            to = 1'b0;
         end
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
endmodule : ealu_host

// >>> verification/ealu_props.sv
`timescale 1ns/1ns
`include "ealu_consts.svh"
// ****************************************************************
// timing, wide zero flag and io status checks at the block pins
// ****************************************************************
module ealu_checker #(
   parameter logic [5:0] IO_REG_ADDR = `EALU_IO_ADDR_DEF,
   parameter logic [7:0] W1C_MASK = `EALU_W1C_DEF
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic [7:0] io_event,
   input wire logic [15:0] result,
   input wire logic result_wide,
   input wire logic op_done,
   input wire logic busy,
   input wire logic [7:0] flags,
   input wire logic [7:0] io_status
);
   logic wr_done, wr_stat, wr_cmd;
   logic [7:0] wlow, cmd_bit, rmw_v;
   assign wr_done = psel && penable && pready && pwrite;
   assign wr_stat = wr_done && (paddr == `EALU_OFS_IO_STAT);
   assign wr_cmd = wr_done && (paddr == `EALU_OFS_IO_CMD);
   assign wlow = pwdata[7:0];
   assign cmd_bit = 8'h01 << pwdata[10:8];
   // what the bit instruction writes back: w1c bits read as set go back as ones
   assign rmw_v = pwdata[12] ? (io_status | cmd_bit) : (io_status & ~cmd_bit);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);

   a_done_pulse: assert property (op_done |=> !op_done)
      else $error("done pulse too long");
   a_byte_timing: assert property (
      op_done && !result_wide |-> !busy && $past(busy) && !$past(busy, 2))
      else $error("byte op not one clock");
   a_word_timing: assert property (
      op_done && result_wide |-> $past(busy) && $past(busy, 2) && !$past(busy, 3))
      else $error("wide op not two clocks");
   a_wide_zero: assert property (
      op_done && result_wide |-> flags[1] == (result == 16'h0000))
      else $error("wide zero flag wrong");
   a_event_sets: assert property (
      |(io_event & W1C_MASK) |=>
      (io_status & $past(io_event) & W1C_MASK) == ($past(io_event) & W1C_MASK))
      else $error("event not recorded");
   a_w1c_clear: assert property (
      wr_stat |=> (io_status & $past(wlow) & W1C_MASK & ~$past(io_event)) == 8'h00)
      else $error("written one did not clear");
   a_plain_store: assert property (
      wr_stat |=> (io_status & ~W1C_MASK) == ($past(wlow) & ~W1C_MASK))
      else $error("plain bits not stored");
   a_zero_keeps: assert property (
      wr_stat |=> ($past(io_status) & ~$past(wlow) & W1C_MASK & ~io_status) == 8'h00)
      else $error("written zero cleared a flag");
   a_rmw_clear: assert property (
      wr_cmd && pwdata[5:0] == IO_REG_ADDR |=> io_status == (($past(rmw_v) & ~W1C_MASK)
      | ($past(io_status) & W1C_MASK & ~$past(rmw_v)) | ($past(io_event) & W1C_MASK)))
      else $error("bit instruction write-back wrong");
   a_io_range: assert property (
      wr_cmd && pwdata[5:0] > 6'h1F |=>
      io_status == ($past(io_status) | ($past(io_event) & W1C_MASK)))
      else $error("out of range bit instruction acted");

   c_byte_op: cover property (op_done && !result_wide);
   c_wide_op: cover property (op_done && result_wide);
   c_rmw: cover property (wr_cmd && pwdata[5:0] == IO_REG_ADDR);
endmodule : ealu_checker

bind ealu_top ealu_checker #(.IO_REG_ADDR(IO_REG_ADDR), .W1C_MASK(W1C_MASK)) u_chk (
   .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready(pready), .io_event(io_event), .result(result),
   .result_wide(result_wide), .op_done(op_done), .busy(busy), .flags(flags),
   .io_status(io_status)
);

// >>> verification/testbench.sv
`timescale 1ns/1ns
`include "ealu_consts.svh"
// ****************************************************************
// self-checking bench
// ****************************************************************
module testbench;
   logic ref_clk, reset, psel, penable, pwrite, pready, pslverr, result_wide, op_done, busy;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [7:0] io_event, flags, io_status;
   logic [15:0] result;
   int fails, check_count;

   ealu_top u_dut (.ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .io_event(io_event), .result(result), .result_wide(result_wide),
      .op_done(op_done), .busy(busy), .flags(flags), .io_status(io_status));
   ealu_host u_host (.ref_clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   task final_report;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : final_report

   task check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
         output logic [31:0] q, output logic e);
      logic to;
      u_host.xfer(wr, a, d, q, e, to);
      if (to) begin
         fails++;
         final_report();
      end
   endtask : xfer

   task wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      xfer(1'b1, a, d, q, e);
   endtask : wr

   task rdchk(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] q;
      logic e;
      xfer(1'b0, a, 32'h00000000, q, e);
      check(q, exp);
   endtask : rdchk

   function automatic logic is_wide(input logic [4:0] op);
      return op == 5'h02 || op == 5'h07 || op >= 5'h16;
   endfunction : is_wide

   // flags are loaded first because they carry the incoming carry
   task run_op(input logic [4:0] op, input logic [7:0] a, b, h, fin);
      int n;
      wr(`EALU_OFS_FLAGS, 32'(fin));
      wr(`EALU_OFS_OPA, 32'(a));
      wr(`EALU_OFS_OPB, 32'(b));
      wr(`EALU_OFS_OPH, 32'(h));
      wr(`EALU_OFS_CTRL, 32'h00000100 | 32'(op));
      n = 0;
      while (op_done !== 1'b1) begin
         @(posedge ref_clk);
         n++;
         if (n > 20) begin
            fails++;
            final_report();
         end
      end
   endtask : run_op

   task chk_op(input logic [4:0] op, input logic [7:0] a, b, h, fin,
         input logic [15:0] res, input logic [7:0] fout);
      run_op(op, a, b, h, fin);
      check(32'(is_wide(op) ? result : {8'h00, result[7:0]}), 32'(res));
      check(32'(flags), 32'(fout));
   endtask : chk_op

   task t_values;
      chk_op(5'h01, 8'h0F, 8'h00, 8'h00, 8'h01, 16'h0010, 8'h20);
      chk_op(5'h02, 8'hFF, 8'h01, 8'hFF, 8'h00, 16'h0000, 8'h03);
      chk_op(5'h03, 8'h00, 8'h01, 8'h00, 8'h00, 16'h00FF, 8'h25);
      chk_op(5'h05, 8'h80, 8'h00, 8'h00, 8'h01, 16'h007F, 8'h28);
      chk_op(5'h06, 8'h00, 8'hFF, 8'h00, 8'h00, 16'h0001, 8'h21);
      chk_op(5'h07, 8'h00, 8'h01, 8'h80, 8'h00, 16'h7FFF, 8'h18);
      chk_op(5'h08, 8'h80, 8'hC0, 8'h00, 8'h08, 16'h0080, 8'h04);
      chk_op(5'h0B, 8'h01, 8'h80, 8'h00, 8'h00, 16'h0081, 8'h04);
      chk_op(5'h10, 8'hF0, 8'hF0, 8'h00, 8'h21, 16'h0000, 8'h23);
      chk_op(5'h13, 8'h90, 8'h00, 8'h00, 8'h08, 16'h0090, 8'h04);
      chk_op(5'h17, 8'h80, 8'h80, 8'h00, 8'h02, 16'h4000, 8'h00);
      chk_op(5'h18, 8'hFF, 8'h02, 8'h00, 8'h00, 16'hFFFE, 8'h01);
      chk_op(5'h19, 8'hFF, 8'hFF, 8'h00, 8'h00, 16'hFC02, 8'h01);
      chk_op(5'h14, 8'h33, 8'h00, 8'h00, 8'h04, 16'h0000, 8'h02);
      chk_op(5'h0E, 8'h80, 8'h00, 8'h00, 8'h00, 16'h0080, 8'h0D);
      chk_op(5'h11, 8'h7F, 8'h00, 8'h00, 8'h01, 16'h0080, 8'h0D);
      chk_op(5'h15, 8'h00, 8'h00, 8'h00, 8'hC3, 16'h00FF, 8'hC3);
   endtask : t_values

   task t_cycles;
      logic [31:0] q;
      logic e;
      for (int i = 0; i < 28; i++) begin
         run_op(5'(i), 8'h00, 8'h00, 8'h00, 8'h00);
         check(32'(result_wide), 32'(is_wide(5'(i))));
         xfer(1'b0, `EALU_OFS_CTRL, 32'h00000000, q, e);
         check(q, 32'(i) | (is_wide(5'(i)) ? 32'h00002000 : 32'h00001000));
      end
   endtask : t_cycles

   task t_refused;
      logic [31:0] q;
      logic e;
      xfer(1'b1, 12'h024, 32'h000000FF, q, e);
      check(32'(e), 32'h00000001);
      xfer(1'b0, 12'h024, 32'h00000000, q, e);
      check(q | 32'(e), 32'h00000001);
      wr(`EALU_OFS_CTRL, 32'h0000011C);
      rdchk(`EALU_OFS_ERR, 32'h00000002);
      wr(`EALU_OFS_ERR, 32'h00000002);
      rdchk(`EALU_OFS_ERR, 32'h00000000);
   endtask : t_refused

   task t_io;
      @(posedge ref_clk) io_event <= 8'h30;
      @(posedge ref_clk) io_event <= 8'h00;
      rdchk(`EALU_OFS_IO_STAT, 32'h00000030);
      wr(`EALU_OFS_IO_STAT, 32'h00000015);
      rdchk(`EALU_OFS_IO_STAT, 32'h00000025);
      wr(`EALU_OFS_IO_CMD, 32'h0000100B);
      rdchk(`EALU_OFS_IO_STAT, 32'h00000005);
      @(posedge ref_clk) io_event <= 8'h80;
      @(posedge ref_clk) io_event <= 8'h00;
      wr(`EALU_OFS_IO_CMD, 32'h0000000B);
      rdchk(`EALU_OFS_IO_STAT, 32'h00000004);
      wr(`EALU_OFS_IO_CMD, 32'h0000121F);
      rdchk(`EALU_OFS_ERR, 32'h00000000);
      wr(`EALU_OFS_IO_CMD, 32'h00001220);
      rdchk(`EALU_OFS_ERR, 32'h00000001);
      rdchk(`EALU_OFS_IO_STAT, 32'h00000004);
   endtask : t_io

   initial begin
      reset = 1'b1;
      io_event = 8'h00;
      fails = 0;
      check_count = 0;
      repeat (10) @(posedge ref_clk);
      reset <= 1'b0;
      t_values();
      t_cycles();
      t_refused();
      t_io();
      final_report();
   end
endmodule : testbench
